// ==== mpsd_pkg.sv ====
// Purpose: constants and types for the modem preamble, spacing and
//          deviation configuration bank
// Assumes: 8-bit registers, each on one aligned 32-bit AXI4-Lite word
// Notes:   printed offsets are register indices; byte address = 4 * index
//
// Behaviour
// (R1) fec enable bit 7 turns on payload-only correction with interleaving.
// (R2) software enables correction only with fixed-length packet format.
// (R3) preamble code bits 6:4 give 2,3,4,6,8,12,16,24 bytes minimum.
// (R4) bits 1:0 of first register hold the channel spacing exponent.
// (R5) spacing mantissa and exponent times slot index add to base carrier.
// (R6) reset spacing fields at 26 MHz crystal give 199.951 kHz.
// (R7) fsk/gfsk transmit: symbol 0 at minus, 1 at plus deviation.
// (R8) deviation exponent bits 6:4, mantissa 2:0 with implied leading one.
// (R9) reset deviation fields at 26.0 MHz crystal give +-47.607 kHz.
// (R10) msk transmit: field picks 1/8..8/8 phase window, +90 for 0, -90 for 1.
// (R11) deviation unused for ask/ook transmit and msk/ask/ook receive.
// (R12) software sets deviation near incoming signal for fsk/gfsk receive.
// (R13) reserved bits read zero and ignore writes.
package mpsd_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0] MPSD_IDX_MODEM_CFG = 8'h13;
	localparam logic [7:0] MPSD_IDX_SPC_MANT = 8'h14;
	localparam logic [7:0] MPSD_IDX_FREQ_SHIFT = 8'h15;
	localparam int MPSD_IDX_SHIFT = 2;
	localparam int MPSD_ADDR_W = 10;
	localparam logic [7:0] MPSD_MODEM_CFG_RST = 8'h22;
	localparam logic [7:0] MPSD_SPC_MANT_RST = 8'hf8;
	localparam logic [7:0] MPSD_FREQ_SHIFT_RST = 8'h47;
	localparam logic [7:0] MPSD_MODEM_CFG_MASK = 8'hf3;
	localparam logic [7:0] MPSD_SPC_MANT_MASK = 8'hff;
	localparam logic [7:0] MPSD_FREQ_SHIFT_MASK = 8'h77;
	// ==========================================================
	// field positions
	localparam int MPSD_FEC_BIT = 7;
	localparam int MPSD_PRE_HI = 6;
	localparam int MPSD_PRE_LO = 4;
	localparam int MPSD_SPE_HI = 1;
	localparam int MPSD_SPE_LO = 0;
	localparam int MPSD_DVE_HI = 6;
	localparam int MPSD_DVE_LO = 4;
	localparam int MPSD_DVM_HI = 2;
	localparam int MPSD_DVM_LO = 0;
	// ==========================================================
	// frequency arithmetic
	localparam int MPSD_XTAL_HZ = 26000000;
	localparam int MPSD_SPC_FRAC_BITS = 18;
	localparam int MPSD_DEV_FRAC_BITS = 17;
	localparam int MPSD_SPC_RST_HZ = 199951;
	localparam int MPSD_DEV_RST_HZ = 47607;
	localparam logic [8:0] MPSD_SPC_IMPLIED = 9'h100;
	localparam logic [3:0] MPSD_DEV_IMPLIED = 4'h8;
	localparam logic [3:0] MPSD_MSK_EIGHTH = 4'h1;
	// ==========================================================
	// bus answers
	localparam logic [1:0] MPSD_RESP_OKAY = 2'h0;
	localparam logic [1:0] MPSD_RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		MPSD_MOD_2FSK = 3'b000,
		MPSD_MOD_GFSK = 3'b001,
		MPSD_MOD_ASK = 3'b011,
		MPSD_MOD_MSK = 3'b111
	} mpsd_mod_t;
	// minimum preamble length in bytes per code
	function automatic logic [4:0] mpsd_preamble_bytes(
		input logic [2:0] code);
		unique case (code)
			3'h0: mpsd_preamble_bytes = 5'h02;
			3'h1: mpsd_preamble_bytes = 5'h03;
			3'h2: mpsd_preamble_bytes = 5'h04;
			3'h3: mpsd_preamble_bytes = 5'h06;
			3'h4: mpsd_preamble_bytes = 5'h08;
			3'h5: mpsd_preamble_bytes = 5'h0c;
			3'h6: mpsd_preamble_bytes = 5'h10;
			3'h7: mpsd_preamble_bytes = 5'h18;
		endcase
	endfunction
endpackage

// ==== mpsd_cfg_if.sv ====
// Purpose: carries register fields and modem state to the arithmetic unit
// Assumes: all signals on sys_clk_i
// Notes:   results are combinational; the top registers them
`timescale 1ns/10ps
interface mpsd_cfg_if;
	logic payload_error_correction_enable;
	logic [2:0] preamble_code;
	logic [1:0] channel_spacing_exponent;
	logic [7:0] channel_spacing_mantissa;
	logic [2:0] dev_exp;
	logic [2:0] dev_mant;
	logic [7:0] rf_slot_index;
	logic [23:0] base_word;
	logic [2:0] mod_format;
	logic tx_active;
	logic rx_active;
	logic tx_symbol;
	logic [4:0] preamble_bytes;
	logic [11:0] spacing_step;
	logic [26:0] carrier_word;
	logic [10:0] dev_word;
	logic signed [11:0] tx_offset;
	logic [3:0] msk_eighths;
	logic msk_phase_up;
	logic [10:0] rx_dev;
	logic fec_active;
	modport cfg (output payload_error_correction_enable, preamble_code, channel_spacing_exponent,
		channel_spacing_mantissa, dev_exp, dev_mant, rf_slot_index,
		base_word, mod_format, tx_active, rx_active, tx_symbol,
		input preamble_bytes, spacing_step, carrier_word, dev_word,
		tx_offset, msk_eighths, msk_phase_up, rx_dev, fec_active);
	modport calc (input payload_error_correction_enable, preamble_code, channel_spacing_exponent,
		channel_spacing_mantissa, dev_exp, dev_mant, rf_slot_index,
		base_word, mod_format, tx_active, rx_active, tx_symbol,
		output preamble_bytes, spacing_step, carrier_word, dev_word,
		tx_offset, msk_eighths, msk_phase_up, rx_dev, fec_active);
endinterface

// ==== mpsd_calc.sv ====
// Purpose: frequency, deviation and preamble arithmetic from the fields
// Assumes: spacing in units of xtal/2^18, deviation in xtal/2^17
// Notes:   purely combinational
`timescale 1ns/10ps
module mpsd_calc
	import mpsd_pkg::*;
(
	mpsd_cfg_if.calc c
);
	// ==========================================================
	// spacing and carrier
	wire [8:0] spc_full;
	wire [19:0] slot_offset;
	wire [26:0] base_scaled;
	// spacing = (256 + m) << e, reset gives 504*4 steps [R4] [R6]
	assign spc_full = MPSD_SPC_IMPLIED | {1'b0, c.channel_spacing_mantissa};
	assign c.spacing_step = {3'h0, spc_full} << c.channel_spacing_exponent;
	assign slot_offset = c.spacing_step * c.rf_slot_index; // [R5]
	// base is xtal/2^16 units; shift to the spacing resolution
	assign base_scaled = {1'b0, c.base_word, 2'h0};
	assign c.carrier_word = base_scaled + {7'h00, slot_offset}; // [R5]
	// ==========================================================
	// deviation
	wire [3:0] dev_full;
	wire is_fsk;
	wire is_msk;
	// implied msb gives 8..15; reset 15<<4 ~ 47.6 kHz [R8] [R9]
	assign dev_full = MPSD_DEV_IMPLIED | {1'b0, c.dev_mant};
	assign c.dev_word = {7'h00, dev_full} << c.dev_exp; // [R8]
	assign is_fsk = (c.mod_format == MPSD_MOD_2FSK) ||
		(c.mod_format == MPSD_MOD_GFSK);
	assign is_msk = (c.mod_format == MPSD_MOD_MSK);
	// symbol picks the sign; ask/ook and idle leave the carrier [R7] [R11]
	assign c.tx_offset = (c.tx_active && is_fsk) ?
		(c.tx_symbol ? $signed({1'b0, c.dev_word}) :
		-$signed({1'b0, c.dev_word})) : 12'sh000;
	// mantissa 0..7 maps to 1/8..8/8 of a symbol [R10]
	assign c.msk_eighths = (c.tx_active && is_msk) ?
		({1'b0, c.dev_mant} + MPSD_MSK_EIGHTH) : 4'h0;
	assign c.msk_phase_up = c.tx_active && is_msk && !c.tx_symbol; // [R10]
	// demodulator expectation only in fsk receive [R11]
	assign c.rx_dev = (c.rx_active && is_fsk) ? c.dev_word : 11'h000;
	// ==========================================================
	// packet side
	assign c.preamble_bytes = mpsd_preamble_bytes(c.preamble_code); // [R3]
	assign c.fec_active = c.payload_error_correction_enable; // [R1]
endmodule

// ==== mpsd_top.sv ====
// Purpose: AXI4-Lite register bank for modem spacing and deviation setup
// Assumes: single clock, synchronous active-low reset, one bus master
// Notes:   derived outputs lag a register write by one cycle
`timescale 1ns/10ps
module mpsd_top
	import mpsd_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	// axi4-lite write address
	input wire logic [MPSD_ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// axi4-lite read address
	input wire logic [MPSD_ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// modem state from the radio controller
	input wire logic [7:0] rf_slot_index_i,
	input wire logic [23:0] base_freq_word_i,
	input wire logic [2:0] mod_format_i,
	input wire logic tx_active_i,
	input wire logic rx_active_i,
	input wire logic tx_symbol_i,
	// settings toward packet engine, synthesizer and modulator
	output logic payload_error_correction_enable_o,
	output logic [4:0] preamble_bytes_o,
	output logic [11:0] channel_spacing_step_o,
	output logic [26:0] carrier_word_o,
	output logic [10:0] deviation_word_o,
	output logic signed [11:0] tx_freq_offset_o,
	output logic [3:0] msk_phase_eighths_o,
	output logic msk_phase_up_o,
	output logic [10:0] rx_expected_dev_o
);
	// ==========================================================
	// address decode helpers
	localparam int SEL_NONE = 0;
	localparam int SEL_CFG = 1;
	localparam int SEL_MANT = 2;
	localparam int SEL_SHIFT = 3;

	// maps a byte address onto a register select, or none
	function automatic logic [1:0] reg_sel(
		input logic [MPSD_ADDR_W-1:0] addr);
		logic [MPSD_ADDR_W-1:0] a_cfg;
		logic [MPSD_ADDR_W-1:0] a_mant;
		logic [MPSD_ADDR_W-1:0] a_shift;
		a_cfg = MPSD_ADDR_W'({MPSD_IDX_MODEM_CFG, 2'h0});
		a_mant = MPSD_ADDR_W'({MPSD_IDX_SPC_MANT, 2'h0});
		a_shift = MPSD_ADDR_W'({MPSD_IDX_FREQ_SHIFT, 2'h0});
		if (addr == a_cfg) begin
			reg_sel = 2'(SEL_CFG);
		end else if (addr == a_mant) begin
			reg_sel = 2'(SEL_MANT);
		end else if (addr == a_shift) begin
			reg_sel = 2'(SEL_SHIFT);
		end else begin
			reg_sel = 2'(SEL_NONE);
		end
	endfunction

	// ==========================================================
	// register storage
	logic [7:0] modem_cfg_fec_preamble_spacing_exp_ff;
	logic [7:0] channel_spacing_mantissa_reg_ff;
	logic [7:0] frequency_shift_setting_ff;
	logic [7:0] nxt_modem_cfg;
	logic [7:0] nxt_spc_mant;
	logic [7:0] nxt_freq_shift;

	// ==========================================================
	// write channel holding
	logic aw_hold_ff;
	logic [MPSD_ADDR_W-1:0] aw_addr_ff;
	logic w_hold_ff;
	logic [7:0] w_byte_ff;
	logic w_lane_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	wire aw_take;
	wire w_take;
	wire do_write;
	wire [1:0] wr_sel;
	wire wr_lane_ok;

	// a full handshake holds off new beats until the response drains
	assign s_axi_awready_o = !aw_hold_ff && !bvalid_ff;
	assign s_axi_wready_o = !w_hold_ff && !bvalid_ff;
	assign aw_take = s_axi_awvalid_i && s_axi_awready_o;
	assign w_take = s_axi_wvalid_i && s_axi_wready_o;
	assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
	assign wr_sel = reg_sel(aw_addr_ff);
	assign wr_lane_ok = w_lane_ff;

	// address and data may arrive in either order
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			aw_hold_ff <= 1'b0;
			aw_addr_ff <= '0;
		end else if (aw_take) begin
			aw_hold_ff <= 1'b1;
			aw_addr_ff <= s_axi_awaddr_i;
		end else if (do_write) begin
			aw_hold_ff <= 1'b0;
		end
	end

	// only byte lane 0 carries register data
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			w_hold_ff <= 1'b0;
			w_byte_ff <= 8'h00;
			w_lane_ff <= 1'b0;
		end else if (w_take) begin
			w_hold_ff <= 1'b1;
			w_byte_ff <= s_axi_wdata_i[7:0];
			w_lane_ff <= s_axi_wstrb_i[0];
		end else if (do_write) begin
			w_hold_ff <= 1'b0;
		end
	end

	// unmapped addresses answer slverr and store nothing
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= MPSD_RESP_OKAY;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= (wr_sel == 2'(SEL_NONE)) ?
				MPSD_RESP_SLVERR : MPSD_RESP_OKAY;
		end else if (s_axi_bready_i) begin
			bvalid_ff <= 1'b0;
		end
	end
	assign s_axi_bvalid_o = bvalid_ff;
	assign s_axi_bresp_o = bresp_ff;

	// ==========================================================
	// register next values
	wire wr_cfg;
	wire wr_mant;
	wire wr_shift;
	assign wr_cfg = do_write && wr_lane_ok && (wr_sel == 2'(SEL_CFG));
	assign wr_mant = do_write && wr_lane_ok && (wr_sel == 2'(SEL_MANT));
	assign wr_shift = do_write && wr_lane_ok && (wr_sel == 2'(SEL_SHIFT));
	// masking on write keeps reserved positions at zero [R13]
	assign nxt_modem_cfg = wr_cfg ? (w_byte_ff & MPSD_MODEM_CFG_MASK) :
		modem_cfg_fec_preamble_spacing_exp_ff;
	assign nxt_spc_mant = wr_mant ? (w_byte_ff & MPSD_SPC_MANT_MASK) :
		channel_spacing_mantissa_reg_ff;
	assign nxt_freq_shift = wr_shift ? (w_byte_ff & MPSD_FREQ_SHIFT_MASK) :
		frequency_shift_setting_ff;

	// reset values give the nominal spacing and deviation [R6] [R9]
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			modem_cfg_fec_preamble_spacing_exp_ff <= MPSD_MODEM_CFG_RST;
			channel_spacing_mantissa_reg_ff <= MPSD_SPC_MANT_RST;
			frequency_shift_setting_ff <= MPSD_FREQ_SHIFT_RST;
		end else begin
			modem_cfg_fec_preamble_spacing_exp_ff <= nxt_modem_cfg;
			channel_spacing_mantissa_reg_ff <= nxt_spc_mant;
			frequency_shift_setting_ff <= nxt_freq_shift;
		end
	end

	// ==========================================================
	// read channel
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	wire ar_take;
	wire [1:0] rd_sel;
	wire [7:0] rd_byte;

	// one read in flight; the next waits for rready
	assign s_axi_arready_o = !rvalid_ff;
	assign ar_take = s_axi_arvalid_i && s_axi_arready_o;
	assign rd_sel = reg_sel(s_axi_araddr_i);
	// stored bytes already hold zero in reserved bits [R13]
	assign rd_byte = (rd_sel == 2'(SEL_CFG)) ?
		modem_cfg_fec_preamble_spacing_exp_ff :
		(rd_sel == 2'(SEL_MANT)) ? channel_spacing_mantissa_reg_ff :
		(rd_sel == 2'(SEL_SHIFT)) ? frequency_shift_setting_ff : 8'h00;

	// upper 24 bits always read as zero
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= MPSD_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= {24'h00_0000, rd_byte};
			rresp_ff <= (rd_sel == 2'(SEL_NONE)) ?
				MPSD_RESP_SLVERR : MPSD_RESP_OKAY;
		end else if (s_axi_rready_i) begin
			rvalid_ff <= 1'b0;
		end
	end
	assign s_axi_rvalid_o = rvalid_ff;
	assign s_axi_rdata_o = rdata_ff;
	assign s_axi_rresp_o = rresp_ff;

	// ==========================================================
	// field extraction toward the arithmetic unit
	mpsd_cfg_if cfg_bus ();

	// correction enable and preamble code [R1] [R3]
	assign cfg_bus.payload_error_correction_enable =
		modem_cfg_fec_preamble_spacing_exp_ff[MPSD_FEC_BIT];
	assign cfg_bus.preamble_code =
		modem_cfg_fec_preamble_spacing_exp_ff[MPSD_PRE_HI:MPSD_PRE_LO];
	// spacing exponent lives in the low two bits [R4]
	assign cfg_bus.channel_spacing_exponent =
		modem_cfg_fec_preamble_spacing_exp_ff[MPSD_SPE_HI:MPSD_SPE_LO];
	assign cfg_bus.channel_spacing_mantissa =
		channel_spacing_mantissa_reg_ff; // [R5]
	// deviation exponent and mantissa [R8]
	assign cfg_bus.dev_exp =
		frequency_shift_setting_ff[MPSD_DVE_HI:MPSD_DVE_LO];
	assign cfg_bus.dev_mant =
		frequency_shift_setting_ff[MPSD_DVM_HI:MPSD_DVM_LO];
	// modem state passes straight in, same clock domain
	assign cfg_bus.rf_slot_index = rf_slot_index_i;
	assign cfg_bus.base_word = base_freq_word_i;
	assign cfg_bus.mod_format = mod_format_i;
	assign cfg_bus.tx_active = tx_active_i;
	assign cfg_bus.rx_active = rx_active_i;
	assign cfg_bus.tx_symbol = tx_symbol_i;

	mpsd_calc u_calc (
		.c(cfg_bus.calc)
	);

	// ==========================================================
	// registered settings outputs
	logic fec_ff;
	logic [4:0] preamble_ff;
	logic [11:0] spacing_ff;
	logic [26:0] carrier_ff;
	logic [10:0] dev_ff;
	logic signed [11:0] tx_off_ff;
	logic [3:0] msk_frac_ff;
	logic msk_up_ff;
	logic [10:0] rx_dev_ff;

	// one-cycle register stage; trades latency for clean timing
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			fec_ff <= 1'b0;
			preamble_ff <= 5'h00;
			spacing_ff <= 12'h000;
			carrier_ff <= 27'h000_0000;
			dev_ff <= 11'h000;
			tx_off_ff <= 12'sh000;
			msk_frac_ff <= 4'h0;
			msk_up_ff <= 1'b0;
			rx_dev_ff <= 11'h000;
		end else begin
			fec_ff <= cfg_bus.fec_active; // [R1]
			preamble_ff <= cfg_bus.preamble_bytes; // [R3]
			spacing_ff <= cfg_bus.spacing_step; // [R5]
			carrier_ff <= cfg_bus.carrier_word; // [R5]
			dev_ff <= cfg_bus.dev_word; // [R8]
			tx_off_ff <= cfg_bus.tx_offset; // [R7] [R11]
			msk_frac_ff <= cfg_bus.msk_eighths; // [R10]
			msk_up_ff <= cfg_bus.msk_phase_up; // [R10]
			rx_dev_ff <= cfg_bus.rx_dev; // [R11]
		end
	end

	assign payload_error_correction_enable_o = fec_ff;
	assign preamble_bytes_o = preamble_ff;
	assign channel_spacing_step_o = spacing_ff;
	assign carrier_word_o = carrier_ff;
	assign deviation_word_o = dev_ff;
	assign tx_freq_offset_o = tx_off_ff;
	assign msk_phase_eighths_o = msk_frac_ff;
	assign msk_phase_up_o = msk_up_ff;
	assign rx_expected_dev_o = rx_dev_ff;
endmodule

// ==== mpsd_top_monitor.sv ====
// Purpose: port-level checks for the modem spacing and deviation bank
// Assumes: one clock, synchronous active-low reset
// Notes:   settings outputs lag their causes by one cycle
`timescale 1ns/10ps
module mpsd_chk
	import mpsd_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_arready_o,
	input wire logic s_axi_rvalid_o,
	input wire logic [7:0] rf_slot_index_i,
	input wire logic [23:0] base_freq_word_i,
	input wire logic [2:0] mod_format_i,
	input wire logic tx_active_i,
	input wire logic rx_active_i,
	input wire logic tx_symbol_i,
	input wire logic [4:0] preamble_bytes_o,
	input wire logic [11:0] channel_spacing_step_o,
	input wire logic [26:0] carrier_word_o,
	input wire logic [10:0] deviation_word_o,
	input wire logic signed [11:0] tx_freq_offset_o,
	input wire logic [3:0] msk_phase_eighths_o,
	input wire logic msk_phase_up_o,
	input wire logic [10:0] rx_expected_dev_o
);
	// ==========================================================
	// modulation decode, kept apart so each check reads short
	wire is_fsk = mod_format_i == MPSD_MOD_2FSK ||
		mod_format_i == MPSD_MOD_GFSK;
	wire fsk_tx = tx_active_i && is_fsk;
	wire msk_tx = tx_active_i && mod_format_i == MPSD_MOD_MSK;
	wire fsk_rx = rx_active_i && is_fsk;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	// ==========================================================
	// bus handshake
	a_write_busy: assert property (
		s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write channel open while answer pending");
	a_read_busy: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read address open while data pending");
	a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o &&
		s_axi_wvalid_i && s_axi_wready_o |-> ##[1:3] s_axi_bvalid_o)
		else $error("no write answer");
	// ==========================================================
	// settings outputs
	a_reset_values: assert property (
		$rose(nrst_i) |=> channel_spacing_step_o == 12'h7e0 &&
		deviation_word_o == 11'h0f0 && preamble_bytes_o == 5'h04)
		else $error("settings after reset wrong");
	a_preamble_code: assert property (
		nrst_i && $past(nrst_i) |-> preamble_bytes_o inside
		{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h18})
		else $error("preamble length not in table");
	a_carrier_sum: assert property (
		nrst_i && $past(nrst_i) |-> carrier_word_o ==
		{$past(base_freq_word_i), 2'h0} +
		channel_spacing_step_o * $past(rf_slot_index_i))
		else $error("carrier word wrong");
	a_fsk_shift: assert property (
		nrst_i && fsk_tx |=> tx_freq_offset_o == ($past(tx_symbol_i) ?
		$signed({1'h0, deviation_word_o}) :
		-$signed({1'h0, deviation_word_o})))
		else $error("fsk offset wrong");
	a_msk_phase: assert property (
		nrst_i && msk_tx |=> msk_phase_up_o == !$past(tx_symbol_i) &&
		msk_phase_eighths_o inside {[4'h1:4'h8]} && tx_freq_offset_o == 0)
		else $error("msk phase wrong");
	a_tx_unused: assert property (
		nrst_i && !fsk_tx && !msk_tx |=> tx_freq_offset_o == 0 &&
		msk_phase_eighths_o == 4'h0 && !msk_phase_up_o)
		else $error("deviation used outside fsk or msk");
	a_rx_expect: assert property (
		nrst_i |=> rx_expected_dev_o ==
		($past(fsk_rx) ? deviation_word_o : 11'h000))
		else $error("receive deviation wrong");
endmodule
bind mpsd_top mpsd_chk mpsd_chk_i (.sys_clk_i, .nrst_i, .s_axi_awvalid_i,
	.s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o,
	.s_axi_arready_o, .s_axi_rvalid_o, .rf_slot_index_i, .base_freq_word_i,
	.mod_format_i, .tx_active_i, .rx_active_i, .tx_symbol_i,
	.preamble_bytes_o, .channel_spacing_step_o, .carrier_word_o,
	.deviation_word_o, .tx_freq_offset_o, .msk_phase_eighths_o,
	.msk_phase_up_o, .rx_expected_dev_o);

// ==== tb.sv ====
// Purpose: self-checking bench for the modem spacing and deviation bank
// Assumes: axi4-lite master in the bench, 40 MHz clock
// Notes:   expected words are worked out by hand from the field layout
`timescale 1ns/10ps
module tb;
	import mpsd_pkg::*;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	logic [9:0] awaddr = '0, araddr = '0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic [7:0] slot = '0;
	logic [23:0] base = '0;
	logic [2:0] mfmt = '0;
	logic txa = 1'h0, rxa = 1'h0, sym = 1'h0;
	wire awready, wready, bvalid, arready, rvalid, fec, mup;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [4:0] pre;
	wire [11:0] step;
	wire [26:0] carr;
	wire [10:0] dev, rxdev;
	wire signed [11:0] offs;
	wire [3:0] eig;
	int n_fail = 0;
	int n_compared = 0;
	always #12.5 clk = ~clk;
	mpsd_top mpsd_top_i (.sys_clk_i(clk), .nrst_i(nrst),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .rf_slot_index_i(slot),
		.base_freq_word_i(base), .mod_format_i(mfmt), .tx_active_i(txa),
		.rx_active_i(rxa), .tx_symbol_i(sym),
		.payload_error_correction_enable_o(fec), .preamble_bytes_o(pre),
		.channel_spacing_step_o(step), .carrier_word_o(carr),
		.deviation_word_o(dev), .tx_freq_offset_o(offs),
		.msk_phase_eighths_o(eig), .msk_phase_up_o(mup),
		.rx_expected_dev_o(rxdev));
	// ==========================================================
	// shared helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("BAD %0t got %0h expected %0h", $time, got, exp);
			n_fail++;
		end
	endtask
	task final_report;
		if (n_fail == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// a leading edge keeps a release and a new request apart in time
	task automatic wr(input logic [9:0] a, input logic [7:0] d,
		input logic [3:0] s, input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		forever begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 1'h0;
			if (wvalid && wready)
				wvalid <= 1'h0;
			if (bvalid === 1'h1) begin
				chk(bresp, er);
				bready <= 1'h0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] ed,
		input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		forever begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'h0;
			if (rvalid === 1'h1) begin
				chk(rdata, {24'h0, ed});
				chk(rresp, er);
				rready <= 1'h0;
				break;
			end
		end
	endtask
	task settle;
		repeat (2) @(negedge clk);
	endtask
	task automatic mdm(input logic [2:0] f, input logic t, r, sy);
		@(posedge clk);
		mfmt <= f;
		txa <= t;
		rxa <= r;
		sym <= sy;
		settle;
	endtask
	// ==========================================================
	// scenarios
	task t_reset;
		@(negedge clk);
		chk(step, 32'h7e0); // spacing word
		chk(dev, 32'hf0); // deviation word
		chk(pre, 32'h4); // preamble length
		chk(fec, 32'h0); // correction off
		rd(10'h4c, 8'h22, MPSD_RESP_OKAY); // config word
		rd(10'h50, 8'hf8, MPSD_RESP_OKAY); // mantissa
		rd(10'h54, 8'h47, MPSD_RESP_OKAY); // deviation
	endtask
	// every preamble code, reserved bits written high each time
	task automatic t_cfg;
		logic [4:0] tbl [8];
		tbl = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h18};
		for (int i = 0; i < 8; i++) begin
			wr(10'h4c, {1'h1, 3'(i), 4'hf}, 4'h1, MPSD_RESP_OKAY);
			rd(10'h4c, {1'h1, 3'(i), 4'h3}, MPSD_RESP_OKAY); // mask
			settle;
			chk(pre, tbl[i]); // length table
			chk(fec, 32'h1); // on, fixed length
		end
		wr(10'h4c, 8'h02, 4'h1, MPSD_RESP_OKAY);
		settle;
		chk(fec, 32'h0); // correction off
	endtask
	// exponent extremes and a write with its byte strobe off
	task t_space;
		wr(10'h50, 8'h00, 4'h1, MPSD_RESP_OKAY);
		wr(10'h4c, 8'h03, 4'h1, MPSD_RESP_OKAY);
		@(posedge clk);
		slot <= 8'h05;
		base <= 24'h000100;
		settle;
		chk(step, 32'h800); // top exponent
		chk(carr, 32'h2c00); // base plus slots
		wr(10'h50, 8'hff, 4'h0, MPSD_RESP_OKAY);
		wr(10'h4c, 8'h00, 4'h1, MPSD_RESP_OKAY);
		settle;
		chk(step, 32'h100); // zero exponent
		wr(10'h50, 8'hff, 4'h1, MPSD_RESP_OKAY);
		settle;
		chk(step, 32'h1ff); // full mantissa
		chk(carr, 32'hdfb); // base plus slots
	endtask
	task t_dev;
		wr(10'h54, 8'hff, 4'h1, MPSD_RESP_OKAY);
		rd(10'h54, 8'h77, MPSD_RESP_OKAY); // reserved masked
		mdm(MPSD_MOD_2FSK, 1'h1, 1'h0, 1'h1);
		chk(dev, 32'h780); // implied one
		chk(offs, 32'h780); // plus shift
		mdm(MPSD_MOD_2FSK, 1'h1, 1'h0, 1'h0);
		chk(offs, -32'sh780); // minus shift
		mdm(MPSD_MOD_GFSK, 1'h1, 1'h0, 1'h1);
		chk(offs, 32'h780); // gaussian shift
		mdm(MPSD_MOD_MSK, 1'h1, 1'h0, 1'h0);
		chk(eig, 32'h8); // full window
		chk(mup, 32'h1); // phase up
		mdm(MPSD_MOD_MSK, 1'h1, 1'h0, 1'h1);
		chk(mup, 32'h0); // phase down
		mdm(MPSD_MOD_ASK, 1'h1, 1'h0, 1'h1);
		chk(offs, 32'h0); // keyed, unused
		chk(eig, 32'h0); // keyed, unused
		mdm(MPSD_MOD_MSK, 1'h0, 1'h1, 1'h0);
		chk(rxdev, 32'h0); // msk receive unused
		mdm(MPSD_MOD_GFSK, 1'h0, 1'h1, 1'h0);
		chk(rxdev, 32'h780); // expected shift
		wr(10'h54, 8'h00, 4'h1, MPSD_RESP_OKAY);
		mdm(MPSD_MOD_MSK, 1'h1, 1'h0, 1'h0);
		chk(dev, 32'h8); // smallest word
		chk(eig, 32'h1); // one eighth
	endtask
	task t_bad;
		wr(10'h58, 8'h12, 4'h1, MPSD_RESP_SLVERR);
		rd(10'h58, 8'h00, MPSD_RESP_SLVERR);
		rd(10'h4c, 8'h00, MPSD_RESP_OKAY); // untouched
	endtask
	// ==========================================================
	// main sequence and watchdog, sized well above the few hundred
	// cycles the scenarios need
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'h1;
		repeat (2) @(posedge clk);
		t_reset;
		t_cfg;
		t_space;
		t_dev;
		t_bad;
		final_report;
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		final_report;
	end
endmodule
